// ### hdl/eas_seq.sv
`timescale 1ns/10ps
`include "eas_map.svh"
// Operation
// - Command 0x87 launches security-flag write.
// - Command 0x81 launches shield-window write.
// - Boot-cluster change swaps only after reset.
// - Swap source: stored flag or temporary select.
// - Stored flag inverted, temporary select direct.
// - Selected cluster maps at address zero.
module eas_seq #(
   parameter bit SMALL_BOOT = 1'b0
) (
   input wire logic i_ref_clk,
   input wire logic i_reset,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic i_main_seq_busy,
   input wire eas_pkg::eas_addr_type i_fetch_addr,
   output eas_pkg::eas_addr_type o_fetch_addr,
   output logic o_extra_busy,
   output logic o_boot_cluster
);
   import eas_pkg::*;

   localparam int OP_CYC = `EAS_OP_CYCLES;

   logic [7:0] flash_area_select, next_flash_area_select;
   logic [7:0] extra_seq_command, next_extra_seq_command;
   // Flash-backed state powers up erased, swap control at 8'h00; reset never touches it
   logic [7:0] boot_swap_temp_control = 8'h00;
   logic [7:0] next_boot_swap_temp_control;
   logic [15:0] security_flag_readback = `EAS_RST_SEC_FLAG;
   logic [15:0] next_security_flag_readback;
   logic [15:0] write_data_low, next_write_data_low;
   logic [15:0] write_data_high, next_write_data_high;
   logic [15:0] shield_start_readback = `EAS_RST_SHLD;
   logic [15:0] next_shield_start_readback;
   logic [15:0] shield_end_readback = `EAS_RST_SHLD;
   logic [15:0] next_shield_end_readback;
   logic data_flash_access_en, next_data_flash_access_en;
   logic code_prog_mode, next_code_prog_mode;
   logic cmd_done, next_cmd_done;
   logic cmd_error, next_cmd_error;
   eas_state_type state, next_state;
   logic [7:0] op_cnt, next_op_cnt;
   logic [2:0] op_code, next_op_code;
   logic boot_cluster, next_boot_cluster;
   logic boot_latched, next_boot_latched;

   logic aw_held, next_aw_held;
   logic [7:0] aw_addr, next_aw_addr;
   logic w_held, next_w_held;
   logic [31:0] w_data, next_w_data;
   logic [3:0] w_strb, next_w_strb;
   logic bvalid, next_bvalid;
   logic [1:0] bresp, next_bresp;
   logic rvalid, next_rvalid;
   logic [31:0] rdata, next_rdata;
   logic [1:0] rresp, next_rresp;

   logic do_write;
   logic [31:0] rd_word;
   logic rd_hit;
   logic wr_hit;
   logic launch;

   function automatic logic [15:0] merge16(input logic [15:0] old,
                                           input logic [31:0] d,
                                           input logic [3:0] s);
      logic [15:0] r;
      r = old;
      if (s[0]) begin
         r[7:0] = d[7:0];
      end
      if (s[1]) begin
         r[15:8] = d[15:8];
      end
      return r;
   endfunction

   assign s_axi_awready = !aw_held && !bvalid;
   assign s_axi_wready = !w_held && !bvalid;
   assign s_axi_arready = !rvalid;
   assign s_axi_bvalid = bvalid;
   assign s_axi_bresp = bresp;
   assign s_axi_rvalid = rvalid;
   assign s_axi_rdata = rdata;
   assign s_axi_rresp = rresp;
   assign do_write = aw_held && w_held && !bvalid;

   always_comb begin
      wr_hit = 1'b1;
      unique case (aw_addr)
         `EAS_ADDR_AREA_SEL, `EAS_ADDR_CMD, `EAS_ADDR_SWAP_CTL,
         `EAS_ADDR_WDATA_LO, `EAS_ADDR_WDATA_HI, `EAS_ADDR_CTRL: begin
            wr_hit = 1'b1;
         end
         `EAS_ADDR_SEC_FLAG, `EAS_ADDR_SHLD_START, `EAS_ADDR_SHLD_END,
         `EAS_ADDR_STATUS: begin
            wr_hit = 1'b1;
         end
         default: begin
            wr_hit = 1'b0;
         end
      endcase
   end

   // A write of the start bit while idle begins an operation, whatever the op-code
   // launch decode
   assign launch = do_write && (aw_addr == `EAS_ADDR_CMD) && w_strb[0] &&
                   w_data[`EAS_BIT_START] && (state == EAS_IDLE);

   always_comb begin
      rd_hit = 1'b1;
      rd_word = 32'h0000_0000;
      unique case (s_axi_araddr)
         `EAS_ADDR_AREA_SEL: rd_word = {24'h000000, flash_area_select};
         `EAS_ADDR_CMD: rd_word = {24'h000000, extra_seq_command};
         `EAS_ADDR_SWAP_CTL: rd_word = {24'h000000, boot_swap_temp_control};
         `EAS_ADDR_SEC_FLAG: rd_word = {16'h0000, security_flag_readback};
         `EAS_ADDR_WDATA_LO: rd_word = {16'h0000, write_data_low};
         `EAS_ADDR_WDATA_HI: rd_word = {16'h0000, write_data_high};
         `EAS_ADDR_SHLD_START: rd_word = {16'h0000, shield_start_readback};
         `EAS_ADDR_SHLD_END: rd_word = {16'h0000, shield_end_readback};
         `EAS_ADDR_STATUS: rd_word = {28'h0000000, boot_cluster,
                                      cmd_error, cmd_done, o_extra_busy};
         `EAS_ADDR_CTRL: rd_word = {30'h00000000, code_prog_mode,
                                    data_flash_access_en};
         default: rd_hit = 1'b0;
      endcase
   end

   always_comb begin
      next_aw_held = aw_held;
      next_aw_addr = aw_addr;
      next_w_held = w_held;
      next_w_data = w_data;
      next_w_strb = w_strb;
      next_bvalid = bvalid;
      next_bresp = bresp;
      next_rvalid = rvalid;
      next_rdata = rdata;
      next_rresp = rresp;
      if (s_axi_awvalid && s_axi_awready) begin
         next_aw_held = 1'b1;
         next_aw_addr = {s_axi_awaddr[7:2], 2'b00};
      end
      if (s_axi_wvalid && s_axi_wready) begin
         next_w_held = 1'b1;
         next_w_data = s_axi_wdata;
         next_w_strb = s_axi_wstrb;
      end
      if (do_write) begin
         next_aw_held = 1'b0;
         next_w_held = 1'b0;
         next_bvalid = 1'b1;
         next_bresp = wr_hit ? 2'b00 : 2'b10;
      end else if (bvalid && s_axi_bready) begin
         next_bvalid = 1'b0;
      end
      if (s_axi_arvalid && s_axi_arready) begin
         next_rvalid = 1'b1;
         next_rdata = rd_word;
         next_rresp = rd_hit ? 2'b00 : 2'b10;
      end else if (rvalid && s_axi_rready) begin
         next_rvalid = 1'b0;
      end
   end

   always_comb begin
      next_flash_area_select = flash_area_select;
      next_extra_seq_command = extra_seq_command;
      next_boot_swap_temp_control = boot_swap_temp_control;
      next_security_flag_readback = security_flag_readback;
      next_write_data_low = write_data_low;
      next_write_data_high = write_data_high;
      next_shield_start_readback = shield_start_readback;
      next_shield_end_readback = shield_end_readback;
      next_data_flash_access_en = data_flash_access_en;
      next_code_prog_mode = code_prog_mode;
      next_cmd_done = cmd_done;
      next_cmd_error = cmd_error;
      next_state = state;
      next_op_cnt = op_cnt;
      next_op_code = op_code;
      next_boot_cluster = boot_cluster;
      next_boot_latched = boot_latched;
      // boot selection sampled once after reset
      if (!boot_latched) begin
         next_boot_latched = 1'b1;
         if (boot_swap_temp_control[`EAS_BIT_TMP_MODE]) begin
            next_boot_cluster = boot_swap_temp_control[`EAS_BIT_TMP_SEL];
         end else begin
            next_boot_cluster = !security_flag_readback[`EAS_BIT_BOOT_FLAG];
         end
      end
      if (do_write && wr_hit) begin
         unique case (aw_addr)
            `EAS_ADDR_AREA_SEL: begin
               if (w_strb[0]) begin
                  next_flash_area_select = w_data[7:0];
               end
            end
            `EAS_ADDR_CMD: begin
               if (w_strb[0]) begin
                  next_extra_seq_command = w_data[7:0];
               end
            end
            `EAS_ADDR_SWAP_CTL: begin
               if (w_strb[0]) begin
                  next_boot_swap_temp_control = w_data[7:0];
               end
            end
            `EAS_ADDR_WDATA_LO: begin
               next_write_data_low = merge16(write_data_low, w_data, w_strb);
            end
            `EAS_ADDR_WDATA_HI: begin
               next_write_data_high = merge16(write_data_high, w_data, w_strb);
            end
            `EAS_ADDR_CTRL: begin
               if (w_strb[0]) begin
                  next_data_flash_access_en = w_data[0];
                  next_code_prog_mode = w_data[1];
               end
            end
            `EAS_ADDR_STATUS: begin
               // Write one to clear; a completing operation wins
               if (w_strb[0] && w_data[1]) begin
                  next_cmd_done = 1'b0;
               end
               if (w_strb[0] && w_data[2]) begin
                  next_cmd_error = 1'b0;
               end
            end
            default: begin
            end
         endcase
      end
      unique case (state)
         EAS_IDLE: begin
            if (launch) begin
               next_op_code = w_data[2:0];
               next_op_cnt = 8'(OP_CYC - 1);
               next_state = EAS_BUSY;
            end
         end
         EAS_BUSY: begin
            if (op_cnt != 8'h00) begin
               next_op_cnt = op_cnt - 8'h01;
            end else begin
               next_state = EAS_IDLE;
               next_cmd_done = 1'b1;
               next_extra_seq_command[`EAS_BIT_START] = 1'b0;
               if (!flash_area_select[`EAS_BIT_EXTRA_SEL] ||
                   !data_flash_access_en || !code_prog_mode) begin
                  next_cmd_error = 1'b1;
               end else if (op_code == `EAS_OP_SECURITY) begin
                  // stored flag updated, swap waits for reset
                  next_security_flag_readback = write_data_low;
               end else if (op_code == `EAS_OP_SHIELD) begin
                  if (!shield_start_readback[`EAS_BIT_SHLD_MOD]) begin
                     next_cmd_error = 1'b1;
                  end else begin
                     next_shield_start_readback = write_data_low;
                     next_shield_end_readback = write_data_high;
                  end
               end else begin
                  next_cmd_error = 1'b1;
               end
            end
         end
      endcase
   end

   always_ff @(posedge i_ref_clk) begin
      if (i_reset) begin
         aw_held <= 1'b0;
         aw_addr <= 8'h00;
         w_held <= 1'b0;
         w_data <= 32'h0000_0000;
         w_strb <= 4'h0;
         bvalid <= 1'b0;
         bresp <= 2'b00;
         rvalid <= 1'b0;
         rdata <= 32'h0000_0000;
         rresp <= 2'b00;
      end else begin
         aw_held <= next_aw_held;
         aw_addr <= next_aw_addr;
         w_held <= next_w_held;
         w_data <= next_w_data;
         w_strb <= next_w_strb;
         bvalid <= next_bvalid;
         bresp <= next_bresp;
         rvalid <= next_rvalid;
         rdata <= next_rdata;
         rresp <= next_rresp;
      end
   end

   // Flash contents survive reset; only volatile control state clears
   always_ff @(posedge i_ref_clk) begin
      security_flag_readback <= next_security_flag_readback;
      shield_start_readback <= next_shield_start_readback;
      shield_end_readback <= next_shield_end_readback;
      boot_swap_temp_control <= next_boot_swap_temp_control;
      if (i_reset) begin
         flash_area_select <= 8'h00;
         extra_seq_command <= 8'h00;
         write_data_low <= `EAS_RST_WDATA;
         write_data_high <= `EAS_RST_WDATA;
         data_flash_access_en <= 1'b0;
         code_prog_mode <= 1'b0;
         cmd_done <= 1'b0;
         cmd_error <= 1'b0;
         state <= EAS_IDLE;
         op_cnt <= 8'h00;
         op_code <= 3'h0;
         boot_cluster <= 1'b0;
         boot_latched <= 1'b0;
      end else begin
         flash_area_select <= next_flash_area_select;
         extra_seq_command <= next_extra_seq_command;
         write_data_low <= next_write_data_low;
         write_data_high <= next_write_data_high;
         data_flash_access_en <= next_data_flash_access_en;
         code_prog_mode <= next_code_prog_mode;
         cmd_done <= next_cmd_done;
         cmd_error <= next_cmd_error;
         state <= next_state;
         op_cnt <= next_op_cnt;
         op_code <= next_op_code;
         boot_cluster <= next_boot_cluster;
         boot_latched <= next_boot_latched;
      end
   end

   // busy seen by host and main sequencer
   assign o_extra_busy = (state == EAS_BUSY) || i_main_seq_busy;
   assign o_boot_cluster = boot_cluster;

   // swap the two low clusters by flipping the cluster address bit
   always_comb begin
      o_fetch_addr = i_fetch_addr;
      if (boot_cluster) begin
         if (SMALL_BOOT) begin
            if (i_fetch_addr <= `EAS_BOOT_END_BIG) begin
               o_fetch_addr[13] = !i_fetch_addr[13];
            end
         end else if (i_fetch_addr <= 20'h07FFF) begin
            o_fetch_addr[14] = !i_fetch_addr[14];
         end
      end
   end

   a_boot_hold: assert property (@(posedge i_ref_clk) disable iff (i_reset)
      boot_latched |=> $stable(boot_cluster))
      else $error("boot cluster changed without reset");
   a_op_len: assert property (@(posedge i_ref_clk) disable iff (i_reset)
      launch |=> (state == EAS_BUSY) [*8])
      else $error("operation ended early");
   a_op_end: assert property (@(posedge i_ref_clk) disable iff (i_reset)
      launch |-> ##[1:25] (state == EAS_IDLE))
      else $error("operation never ended");
   a_busy_out: assert property (@(posedge i_ref_clk) disable iff (i_reset)
      (state == EAS_BUSY) |-> o_extra_busy)
      else $error("busy not shown");
   a_map_swap: assert property (@(posedge i_ref_clk) disable iff (i_reset)
      (!boot_cluster || i_fetch_addr > 20'h07FFF) |->
      o_fetch_addr == i_fetch_addr)
      else $error("address remapped for cluster 0");
   a_pol_store: assert property (@(posedge i_ref_clk) disable iff (i_reset)
      $rose(boot_latched) && !$past(boot_swap_temp_control[7]) |->
      boot_cluster == !$past(security_flag_readback[8]))
      else $error("stored flag polarity wrong");
   a_pol_temp: assert property (@(posedge i_ref_clk) disable iff (i_reset)
      $rose(boot_latched) && $past(boot_swap_temp_control[7]) |->
      boot_cluster == $past(boot_swap_temp_control[6]))
      else $error("temporary select ignored");
   a_done_flag: assert property (@(posedge i_ref_clk) disable iff (i_reset)
      (state == EAS_BUSY) && (op_cnt == 8'h00) |=> cmd_done)
      else $error("completion not flagged");
endmodule

// ### hdl/eas_map.svh
`ifndef EAS_MAP_SVH
`define EAS_MAP_SVH
// Register byte addresses
`define EAS_ADDR_AREA_SEL 8'h00
`define EAS_ADDR_CMD 8'h04
`define EAS_ADDR_SWAP_CTL 8'h08
`define EAS_ADDR_SEC_FLAG 8'h0C
`define EAS_ADDR_WDATA_LO 8'h10
`define EAS_ADDR_WDATA_HI 8'h14
`define EAS_ADDR_SHLD_START 8'h18
`define EAS_ADDR_SHLD_END 8'h1C
`define EAS_ADDR_STATUS 8'h20
`define EAS_ADDR_CTRL 8'h24
// Field positions
`define EAS_BIT_EXTRA_SEL 0
`define EAS_BIT_START 7
`define EAS_BIT_BOOT_FLAG 8
`define EAS_BIT_BOOT_PROT 9
`define EAS_BIT_SHLD_MOD 15
`define EAS_BIT_TMP_MODE 7
`define EAS_BIT_TMP_SEL 6
// Command and reset values
`define EAS_OP_SECURITY 3'h7
`define EAS_OP_SHIELD 3'h1
`define EAS_CMD_SECURITY 8'h87
`define EAS_CMD_SHIELD 8'h81
`define EAS_RST_SEC_FLAG 16'hFFFF
`define EAS_RST_SHLD 16'hFFFF
`define EAS_RST_WDATA 16'h0000
// Busy time of one extra-area operation
`define EAS_OP_TIME_NS 200
`define EAS_CLK_NS 10
`define EAS_OP_CYCLES ((`EAS_OP_TIME_NS + `EAS_CLK_NS - 1) / `EAS_CLK_NS)
// Boot cluster windows
`define EAS_BOOT_END_BIG 20'h03FFF
`define EAS_BOOT_END_SMALL 20'h01FFF
`endif

// ### hdl/eas_pkg.sv
package eas_pkg;
   typedef enum logic [1:0] {
      EAS_IDLE = 2'b01,
      EAS_BUSY = 2'b10
   } eas_state_type;
   typedef logic [19:0] eas_addr_type;
endpackage

// ### test/eas_host.sv
`timescale 1ns/10ps
`include "eas_map.svh"
module eas_host (
   input wire logic i_ref_clk,
   input wire logic i_busy,
   output logic [7:0] o_awaddr = 8'h00,
   output logic o_awvalid = 1'b0,
   input wire logic i_awready,
   output logic [31:0] o_wdata = 32'h0,
   output logic o_wvalid = 1'b0,
   input wire logic i_wready,
   input wire logic [1:0] i_bresp,
   input wire logic i_bvalid,
   output logic o_bready = 1'b0,
   output logic [7:0] o_araddr = 8'h00,
   output logic o_arvalid = 1'b0,
   input wire logic i_arready,
   input wire logic [31:0] i_rdata,
   input wire logic [1:0] i_rresp,
   input wire logic i_rvalid,
   output logic o_rready = 1'b0
);
   int tmo = 0;
   logic [1:0] resp = 2'h0;
   // Handshakes are sampled mid-cycle; slave outputs only move on a rise
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic at, wt, bt;
      @(posedge i_ref_clk);
      o_awaddr <= a;
      o_wdata <= d;
      o_awvalid <= 1'b1;
      o_wvalid <= 1'b1;
      o_bready <= 1'b1;
      for (int n = 0; n < 100; n++) begin
         @(negedge i_ref_clk);
         at = o_awvalid && i_awready;
         wt = o_wvalid && i_wready;
         bt = i_bvalid;
         resp = i_bresp;
         @(posedge i_ref_clk);
         if (at) o_awvalid <= 1'b0;
         if (wt) o_wvalid <= 1'b0;
         if (bt) begin
            o_bready <= 1'b0;
            return;
         end
      end
      tmo++;
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      logic at, rt;
      d = 32'h0;
      @(posedge i_ref_clk);
      o_araddr <= a;
      o_arvalid <= 1'b1;
      o_rready <= 1'b1;
      for (int n = 0; n < 100; n++) begin
         @(negedge i_ref_clk);
         at = o_arvalid && i_arready;
         rt = i_rvalid;
         d = i_rdata;
         resp = i_rresp;
         @(posedge i_ref_clk);
         if (at) o_arvalid <= 1'b0;
         if (rt) begin
            o_rready <= 1'b0;
            return;
         end
      end
      tmo++;
   endtask
   task automatic run(input logic [7:0] area, input logic [15:0] lo, hi,
                      input logic [7:0] code, output logic [31:0] st0, st);
      for (int n = 0; n < 100; n++) begin
         @(negedge i_ref_clk);
         if (!i_busy) break;
      end
      wr(`EAS_ADDR_AREA_SEL, {24'h0, area});
      wr(`EAS_ADDR_WDATA_LO, {16'h0, lo});
      wr(`EAS_ADDR_WDATA_HI, {16'h0, hi});
      wr(`EAS_ADDR_CMD, {24'h0, code});
      rd(`EAS_ADDR_STATUS, st0);
      st = st0;
      for (int n = 0; n < 100 && st[2:1] == 2'h0; n++)
         rd(`EAS_ADDR_STATUS, st);
      if (st[2:1] == 2'h0) tmo++;
      wr(`EAS_ADDR_STATUS, 32'h6);
   endtask
   task automatic arm;
      logic [31:0] c, f;
      rd(`EAS_ADDR_SWAP_CTL, c);
      rd(`EAS_ADDR_SEC_FLAG, f);
      // arm temporary swap; the two select bits have opposite polarity
      if (c[7] == 1'b0) wr(`EAS_ADDR_SWAP_CTL, {24'h0, 1'b1, ~f[8], c[5:0]});
   endtask
endmodule

// ### test/tb_extra_area_security_flag_seq.sv
`timescale 1ns/10ps
`include "eas_map.svh"
module tb_extra_area_security_flag_seq;
   logic i_ref_clk = 1'b0;
   logic i_reset = 1'b1;
   logic i_main_seq_busy = 1'b0;
   eas_pkg::eas_addr_type i_fetch_addr = 20'h00000;
   eas_pkg::eas_addr_type o_fetch_addr;
   logic [7:0] awaddr, araddr;
   logic awvalid, awready, wvalid, wready, bvalid, bready;
   logic arvalid, arready, rvalid, rready, o_extra_busy, o_boot_cluster;
   logic [31:0] wdata, rdata, v, e, s0, s;
   logic [1:0] bresp, rresp;
   int err_total = 0;
   int total_checks = 0;
   eas_seq dut (.i_ref_clk(i_ref_clk), .i_reset(i_reset),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
      .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
      .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
      .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
      .s_axi_rready(rready), .i_main_seq_busy(i_main_seq_busy),
      .i_fetch_addr(i_fetch_addr), .o_fetch_addr(o_fetch_addr),
      .o_extra_busy(o_extra_busy), .o_boot_cluster(o_boot_cluster));
   eas_host host (.i_ref_clk(i_ref_clk), .i_busy(o_extra_busy),
      .o_awaddr(awaddr), .o_awvalid(awvalid), .i_awready(awready),
      .o_wdata(wdata), .o_wvalid(wvalid), .i_wready(wready),
      .i_bresp(bresp), .i_bvalid(bvalid), .o_bready(bready),
      .o_araddr(araddr), .o_arvalid(arvalid), .i_arready(arready),
      .i_rdata(rdata), .i_rresp(rresp), .i_rvalid(rvalid),
      .o_rready(rready));
   initial begin
      forever #5 i_ref_clk = ~i_ref_clk;
   end
   task chk(input string nm, input logic [31:0] seen, exp);
      total_checks++;
      if (seen !== exp) begin
         err_total++;
         $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task stop_test;
      err_total += host.tmo;
      $display("Counts: checks %0d errors %0d", total_checks, err_total);
      if (err_total == 0 && total_checks > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   task w(input logic [7:0] a, input logic [31:0] d);
      host.wr(a, d);
      if (host.tmo != 0) stop_test();
   endtask
   task r(input logic [7:0] a, output logic [31:0] d);
      host.rd(a, d);
      if (host.tmo != 0) stop_test();
   endtask
   task cmd(input logic [15:0] lo, hi, input logic [7:0] c);
      host.run(8'h01, lo, hi, c, s0, s);
      if (host.tmo != 0) stop_test();
   endtask
   task rst;
      @(posedge i_ref_clk);
      i_reset <= 1'b1;
      repeat (5) @(posedge i_ref_clk);
      i_reset <= 1'b0;
      repeat (2) @(posedge i_ref_clk);
      w(`EAS_ADDR_CTRL, 32'h3);
   endtask
   // Logical fetch addresses in both clusters of the boot window
   task boot(input logic b);
      for (int k = 0; k < 2; k++) begin
         @(posedge i_ref_clk);
         i_fetch_addr <= k ? 20'h04010 : 20'h00010;
         @(negedge i_ref_clk);
         chk("boot", o_boot_cluster, b);
         chk("fetch", o_fetch_addr, i_fetch_addr ^ (b ? 20'h4000 : 0));
      end
   endtask
   initial begin
      logic [7:0] tc[3] = '{8'h00, 8'hC0, 8'h80};
      logic te[3] = '{1'b1, 1'b1, 1'b0};
      logic [7:0] ec[4] = '{8'h03, 8'h02, 8'h01, 8'h03};
      logic [7:0] eo[4] = '{8'h87, 8'h87, 8'h87, 8'h82};
      rst();
      w(`EAS_ADDR_SWAP_CTL, 32'h0);
      cmd(16'hFFFF, 16'hFFFF, `EAS_CMD_SECURITY);
      r(`EAS_ADDR_SEC_FLAG, v);
      chk("sec", v, 32'hFFFF);
      rst();
      boot(1'b0);
      host.arm();
      r(`EAS_ADDR_SWAP_CTL, v);
      chk("swap", v, 32'h80);
      cmd(16'hFEFF, 16'hFFFF, `EAS_CMD_SECURITY);
      chk("busy", s0[0], 1'b1);
      chk("err", s[2], 1'b0);
      boot(1'b0);
      r(`EAS_ADDR_SEC_FLAG, v);
      chk("sec", v, 32'hFEFF);
      rst();
      boot(1'b0);
      for (int i = 0; i < 3; i++) begin
         w(`EAS_ADDR_SWAP_CTL, {24'h0, tc[i]});
         boot(i == 0 ? 1'b0 : te[i > 0 ? i - 1 : 0]);
         rst();
         boot(te[i]);
      end
      r(`EAS_ADDR_SEC_FLAG, v);
      cmd(v[15:0] & 16'hFDFF, 16'hFFFF, `EAS_CMD_SECURITY);
      r(`EAS_ADDR_SEC_FLAG, v);
      chk("sec", v, 32'hFEFF & ~32'h0200);
      cmd(16'h8005, 16'h8010, `EAS_CMD_SHIELD);
      r(`EAS_ADDR_SHLD_START, v);
      r(`EAS_ADDR_SHLD_END, e);
      chk("shield", {v[15:0], e[15:0]}, 32'h8005_8010);
      cmd((v[15:0] | 16'h7E00) & 16'h7FFF, e[15:0] | 16'h7E00,
          `EAS_CMD_SHIELD);
      r(`EAS_ADDR_SHLD_START, v);
      r(`EAS_ADDR_SHLD_END, e);
      chk("shield", {v[15:0], e[15:0]}, 32'h7E05_FE10);
      cmd(16'hFFFF, 16'hFFFF, `EAS_CMD_SHIELD);
      chk("err", s[2], 1'b1);
      r(`EAS_ADDR_SHLD_START, v);
      chk("start", v, 32'h7E05);
      for (int i = 0; i < 4; i++) begin
         w(`EAS_ADDR_CTRL, {24'h0, ec[i]});
         host.run(i == 0 ? 8'h00 : 8'h01, 16'h0, 16'hFFFF, eo[i], s0, s);
         chk("err", s[2], 1'b1);
         r(`EAS_ADDR_SEC_FLAG, v);
         chk("sec", v, 32'hFCFF);
      end
      w(`EAS_ADDR_CTRL, 32'h3);
      @(posedge i_ref_clk);
      i_main_seq_busy <= 1'b1;
      @(negedge i_ref_clk);
      chk("busy", o_extra_busy, 1'b1);
      @(posedge i_ref_clk);
      i_main_seq_busy <= 1'b0;
      @(negedge i_ref_clk);
      chk("busy", o_extra_busy, 1'b0);
      w(8'h30, 32'h0);
      chk("bresp", host.resp, 2'h2);
      r(8'h30, v);
      chk("rd", {host.resp, v[29:0]}, 32'h8000_0000);
      w(`EAS_ADDR_SEC_FLAG, 32'h1234);
      r(`EAS_ADDR_SEC_FLAG, v);
      chk("ro", v, 32'hFCFF);
      r(`EAS_ADDR_AREA_SEL, v);
      chk("area", v, 32'h1);
      stop_test();
   end
   initial begin
      repeat (100000) @(posedge i_ref_clk);
      err_total++;
      stop_test();
   end
endmodule
